//--- dcc_cal_ctrl.sv
/*
 * calibration control registers: channel one resistor setting, calibration
 * configuration, comparator offset result with start, and settings transfer.
 * assumes a register port from the serial-port engine on sys_clk and an
 * analog calibration engine on the same clock that reports done with results.
 */
`timescale 1ns/1ps
// Contract
// - enable written; read shows enable during calibration
// - calibrated resistor code read only
// - resistor setting resets 0x0a, 800 ohm steps
// - six overflow underflow flags, bits 14..9
// - clear pulse discards all calibration results
// - read only flag: calibration in use
// - gain calibration enable bit
// - gate passes divided calibration clock
// - divider is two to field plus two
// - seven bit comparator offset result read only
// - done flag set when calibration completes
// - start bit begins a calibration cycle
// - update applies pending settings, then self clears
module dcc_cal_ctrl
    import dcc_pkg::*;
(
    // clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              ce,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // calibration engine results
    input  wire logic              cal_done_in,
    input  wire logic [4:0]        cal_rset_code_in,
    input  wire logic [6:0]        cal_comp_offset_in,
    input  wire logic [5:0]        cal_flags_in,
    // active settings and engine control
    output logic                   internal_resistor_enable,
    output logic [4:0]             resistor_setting,
    output logic                   gain_cal_enable,
    output logic [1:0]             comp_cal_range,
    output logic                   cal_busy,
    output logic                   cal_start,
    output logic                   cal_clear,
    output logic                   cal_tick,
    output logic                   shadow_settings_transfer
);

    typedef enum logic {ST_IDLE, ST_RUN} dcc_cal_state_t;

    typedef struct packed
    {
        logic           pnd_rset_en;
        logic [4:0]     pnd_rset;
        logic           pnd_gain_en;
        logic [1:0]     pnd_rng;
        logic           pnd_clk_en;
        logic [2:0]     pnd_div;
        logic           act_rset_en;
        logic [4:0]     act_rset;
        logic           act_gain_en;
        logic [1:0]     act_rng;
        logic           act_clk_en;
        logic [2:0]     act_div;
        logic           clr_bit;
        logic           start_bit;
        logic           xfer;
        logic           start_p;
        logic           clear_p;
        dcc_cal_state_t cal_st;
        logic           done;
        logic [4:0]     rset_cal;
        logic [6:0]     comp_off;
        logic [5:0]     flags;
        logic [15:0]    rdata;
    } dcc_core_state_t;

    dcc_core_state_t st_ff;
    dcc_core_state_t nxt_st;
    logic            wr_rset;
    logic            wr_cfg;
    logic            wr_comp;
    logic            wr_xfer;
    logic            do_start;
    logic            do_clear;

    // ************************************************************
    // write decode
    // ************************************************************
    assign wr_rset  = reg_wr && (reg_addr == OFS_RSET1);
    assign wr_cfg   = reg_wr && (reg_addr == OFS_CALCFG);
    assign wr_comp  = reg_wr && (reg_addr == OFS_COMPOFF);
    assign wr_xfer  = reg_wr && (reg_addr == OFS_XFER);
    assign do_start = wr_comp && reg_wdata[START_BIT] && (st_ff.cal_st == ST_IDLE);
    assign do_clear = wr_cfg && reg_wdata[CFG_CLR_BIT] && !st_ff.clr_bit;

    // ************************************************************
    // next state
    // ************************************************************
    // pending settings land on writes; only the transfer strobe makes
    // them active, so a half-written setup never reaches the analog side
    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.xfer    = wr_xfer && reg_wdata[XFER_BIT];
        nxt_st.start_p = do_start;
        nxt_st.clear_p = do_clear;
        if (wr_rset)
        begin
            nxt_st.pnd_rset_en = reg_wdata[RSET_EN_BIT];
            nxt_st.pnd_rset    = reg_wdata[RSET_LSB +: 5];
        end
        if (wr_cfg)
        begin
            nxt_st.clr_bit     = reg_wdata[CFG_CLR_BIT];
            nxt_st.pnd_gain_en = reg_wdata[CFG_GAIN_BIT];
            nxt_st.pnd_rng     = reg_wdata[CFG_RNG_LSB +: 2];
            nxt_st.pnd_clk_en  = reg_wdata[CFG_CLK_BIT];
            nxt_st.pnd_div     = reg_wdata[CFG_DIV_LSB +: 3];
        end
        if (wr_comp)
        begin
            nxt_st.start_bit = reg_wdata[START_BIT];
        end
        // settings transfer: the self-clearing strobe copies all at once
        if (st_ff.xfer)
        begin
            nxt_st.act_rset_en = st_ff.pnd_rset_en;
            nxt_st.act_rset    = st_ff.pnd_rset;
            nxt_st.act_gain_en = st_ff.pnd_gain_en;
            nxt_st.act_rng     = st_ff.pnd_rng;
            nxt_st.act_clk_en  = st_ff.pnd_clk_en;
            nxt_st.act_div     = st_ff.pnd_div;
        end
        // clear first, so that a result arriving in the same cycle wins
        if (do_clear)
        begin
            nxt_st.rset_cal = '0;
            nxt_st.comp_off = '0;
            nxt_st.flags    = '0;
            nxt_st.done     = 1'b0;
        end
        case (st_ff.cal_st)
            ST_IDLE:
            begin
                if (do_start)
                begin
                    nxt_st.cal_st = ST_RUN;
                    nxt_st.done   = 1'b0;
                end
            end
            ST_RUN:
            begin
                if (cal_done_in)
                begin
                    nxt_st.cal_st   = ST_IDLE;
                    nxt_st.done     = 1'b1;
                    nxt_st.rset_cal = cal_rset_code_in;
                    nxt_st.comp_off = cal_comp_offset_in;
                    nxt_st.flags    = cal_flags_in;
                end
            end
            default:
            begin
                nxt_st.cal_st = ST_IDLE;
            end
        endcase
        // read data, registered; unmapped offsets and reserved bits read zero
        if (reg_rd)
        begin
            nxt_st.rdata = '0;
            case (reg_addr)
                OFS_RSET1:
                begin
                    nxt_st.rdata[RSET_EN_BIT] = st_ff.act_rset_en && (st_ff.cal_st == ST_RUN);
                    nxt_st.rdata[RSET_CAL_LSB +: 5] = st_ff.rset_cal;
                    nxt_st.rdata[RSET_LSB +: 5]     = st_ff.pnd_rset;
                end
                OFS_CALCFG:
                begin
                    nxt_st.rdata[CFG_FLAG_LSB +: 6] = st_ff.flags;
                    nxt_st.rdata[CFG_CLR_BIT]       = st_ff.clr_bit;
                    nxt_st.rdata[CFG_MODE_BIT]      = (st_ff.cal_st == ST_RUN);
                    nxt_st.rdata[CFG_GAIN_BIT]      = st_ff.pnd_gain_en;
                    nxt_st.rdata[CFG_RNG_LSB +: 2]  = st_ff.pnd_rng;
                    nxt_st.rdata[CFG_CLK_BIT]       = st_ff.pnd_clk_en;
                    nxt_st.rdata[CFG_DIV_LSB +: 3]  = st_ff.pnd_div;
                end
                OFS_COMPOFF:
                begin
                    nxt_st.rdata[COMP_LSB +: 7] = st_ff.comp_off;
                    nxt_st.rdata[DONE_BIT]      = st_ff.done;
                    nxt_st.rdata[START_BIT]     = st_ff.start_bit;
                end
                OFS_XFER:
                begin
                    nxt_st.rdata[XFER_BIT] = st_ff.xfer;
                end
                default:
                begin
                    nxt_st.rdata = '0;
                end
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    // ce low freezes everything, including the divider
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            st_ff          <= '0;
            st_ff.pnd_rset <= RSET_RST;
            st_ff.act_rset <= RSET_RST;
            st_ff.pnd_div  <= DIV_RST;
            st_ff.act_div  <= DIV_RST;
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    // divided calibration clock; software keeps it under the limit
    dcc_cal_clk_div u_div
    (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .ce       (ce),
        .gate_en  (st_ff.act_clk_en),
        .div_sel  (st_ff.act_div),
        .cal_tick (cal_tick)
    );

    // outputs straight from the state register
    assign reg_rdata                = st_ff.rdata;
    assign internal_resistor_enable = st_ff.act_rset_en;
    assign resistor_setting         = st_ff.act_rset;
    assign gain_cal_enable          = st_ff.act_gain_en;
    assign comp_cal_range           = st_ff.act_rng;
    assign cal_busy                 = (st_ff.cal_st == ST_RUN);
    assign cal_start                = st_ff.start_p;
    assign cal_clear                = st_ff.clear_p;
    assign shadow_settings_transfer = st_ff.xfer;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_xfer_pulse;
        shadow_settings_transfer ##1 !shadow_settings_transfer;
    endsequence

    chk_xfer_self_clear: assert property (@(posedge sys_clk) disable iff (srst || !ce)
        (wr_xfer && reg_wdata[XFER_BIT]) |=> s_xfer_pulse)
        else $error("transfer strobe did not self clear");

    chk_xfer_copies: assert property (@(posedge sys_clk) disable iff (srst || !ce)
        shadow_settings_transfer |=> resistor_setting == $past(st_ff.pnd_rset)
            && gain_cal_enable == $past(st_ff.pnd_gain_en))
        else $error("transfer did not copy pending settings");

    chk_rset_default: assert property (@(posedge sys_clk)
        srst |=> resistor_setting == RSET_RST && st_ff.pnd_rset == RSET_RST)
        else $error("resistor setting reset value wrong");

    chk_start_runs: assert property (@(posedge sys_clk) disable iff (srst || !ce)
        do_start |=> cal_busy && cal_start && !st_ff.done)
        else $error("start did not begin calibration");

    chk_done_sets: assert property (@(posedge sys_clk) disable iff (srst || !ce)
        (cal_busy && cal_done_in) |=> !cal_busy && st_ff.done
            && st_ff.comp_off == $past(cal_comp_offset_in))
        else $error("completion not recorded");

    chk_clear_results: assert property (@(posedge sys_clk) disable iff (srst || !ce)
        (do_clear && !(cal_busy && cal_done_in)) |=> cal_clear && !st_ff.done
            && st_ff.flags == 6'h00 && st_ff.rset_cal == 5'h00)
        else $error("clear left results behind");

    chk_done_holds: assert property (@(posedge sys_clk) disable iff (srst || !ce)
        (st_ff.done && !do_start && !do_clear) |=> st_ff.done)
        else $error("done dropped without restart or clear");

    chk_cal_ro: assert property (@(posedge sys_clk) disable iff (srst || !ce)
        (wr_rset && !(cal_busy && cal_done_in) && !do_clear) |=> $stable(st_ff.rset_cal))
        else $error("write altered calibrated code");

    chk_flags_read: assert property (@(posedge sys_clk) disable iff (srst || !ce)
        (reg_rd && reg_addr == OFS_CALCFG) |=> reg_rdata[CFG_FLAG_LSB +: 6] == $past(st_ff.flags)
            && reg_rdata[CFG_MODE_BIT] == $past(cal_busy))
        else $error("calibration flags read wrong");

endmodule // dcc_cal_ctrl

//--- dcc_pkg.sv
/*
 * constants shared by the calibration control block: register offsets,
 * field positions, reset values and the divider ratio function.
 * assumes one register port driven by the serial-port engine on sys_clk.
 */
package dcc_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 16;
    localparam logic [6:0] OFS_RSET1   = 7'h0c;
    localparam logic [6:0] OFS_CALCFG  = 7'h0d;
    localparam logic [6:0] OFS_COMPOFF = 7'h0e;
    localparam logic [6:0] OFS_XFER    = 7'h1d;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned RSET_EN_BIT  = 15;
    localparam int unsigned RSET_CAL_LSB = 8;
    localparam int unsigned RSET_LSB     = 0;
    localparam int unsigned CFG_FLAG_LSB = 9;
    localparam int unsigned CFG_CLR_BIT  = 8;
    localparam int unsigned CFG_MODE_BIT = 7;
    localparam int unsigned CFG_GAIN_BIT = 6;
    localparam int unsigned CFG_RNG_LSB  = 4;
    localparam int unsigned CFG_CLK_BIT  = 3;
    localparam int unsigned CFG_DIV_LSB  = 0;
    localparam int unsigned COMP_LSB     = 8;
    localparam int unsigned DONE_BIT     = 1;
    localparam int unsigned START_BIT    = 0;
    localparam int unsigned XFER_BIT     = 0;

    // ************************************************************
    // reset values and limits
    // ************************************************************
    localparam logic [4:0] RSET_RST     = 5'h0a;
    localparam logic [4:0] RSET_MIN     = 5'h05;
    localparam logic [4:0] RSET_MAX     = 5'h14;
    localparam int unsigned RSET_OHM_PER_CODE = 800;
    localparam logic [2:0] DIV_RST      = 3'h0;
    localparam int unsigned DIV_EXP_OFS = 2;
    localparam int unsigned SYS_CLK_HZ  = 40000000;
    localparam int unsigned CAL_CLK_MAX_HZ = 500000;

    // dac clock cycles per calibration clock: 2 ** (sel + 2)
    function automatic logic [9:0] dcc_div_ratio(input logic [2:0] sel);
        dcc_div_ratio = 10'h001 << (int'(sel) + DIV_EXP_OFS);
    endfunction

endpackage

//--- dcc_cal_clk_div.sv
/*
 * calibration clock divider: one-cycle tick every 2**(sel+2) sys_clk cycles.
 * assumes sel only changes while the gate is low or at an update strobe.
 */
`timescale 1ns/1ps
module dcc_cal_clk_div
    import dcc_pkg::*;
(
    // clock, reset, enable
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       ce,
    // control
    input  wire logic       gate_en,
    input  wire logic [2:0] div_sel,
    // calibration clock tick
    output logic            cal_tick
);

    typedef struct packed
    {
        logic [9:0] cnt;
        logic       tick;
    } dcc_div_state_t;

    dcc_div_state_t st_ff;
    dcc_div_state_t nxt_st;

    // count while gated on; a closed gate also restarts the phase
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (!gate_en)
        begin
            nxt_st.cnt = '0;
        end
        else if (st_ff.cnt >= dcc_div_ratio(div_sel) - 10'h001)
        begin
            nxt_st.cnt  = '0;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 10'h001;
        end
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            st_ff <= '0;
        else if (ce)
            st_ff <= nxt_st;
    end

    assign cal_tick = st_ff.tick;

    // ************************************************************
    // checks
    // ************************************************************
    chk_tick_gated: assert property (@(posedge sys_clk) disable iff (srst || !ce)
        !gate_en |=> !cal_tick)
        else $error("calibration tick while gate closed");

    sequence s_div4_tick;
        cal_tick && gate_en && div_sel == 3'h0;
    endsequence

    sequence s_div4_held;
        (gate_en && div_sel == 3'h0) [*4];
    endsequence

    // a tick, three quiet cycles, then the next tick while divide by four holds
    chk_tick_period: assert property (@(posedge sys_clk) disable iff (srst || !ce)
        s_div4_tick ##1 s_div4_held
        |-> cal_tick && !$past(cal_tick, 1) && !$past(cal_tick, 2) && !$past(cal_tick, 3))
        else $error("divide by four period wrong");

endmodule // dcc_cal_clk_div

//--- tb_top.sv
/*
 * self-checking bench for the calibration control block: registers,
 * settings transfer, divider ticks, calibration runs and results clear.
 * assumes the block's own assertions live inside the design files.
 */
`timescale 1ns/1ps
module tb_top
    import dcc_pkg::*;
;
    // ************************************************************
    // stimulus, observed outputs and bookkeeping
    // ************************************************************
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic [6:0]  reg_addr = 7'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        cal_done_in = 1'b0;
    logic [4:0]  cal_rset_code_in = 5'h00;
    logic [6:0]  cal_comp_offset_in = 7'h00;
    logic [5:0]  cal_flags_in = 6'h00;
    logic        internal_resistor_enable;
    logic [4:0]  resistor_setting;
    logic        gain_cal_enable;
    logic [1:0]  comp_cal_range;
    logic        cal_busy;
    logic        cal_start;
    logic        cal_clear;
    logic        cal_tick;
    logic        shadow_settings_transfer;
    logic [15:0] rd_val;
    logic [15:0] rset_w;
    logic [15:0] cfg_w;
    logic [4:0]  code_e;
    logic [6:0]  off_e;
    logic [5:0]  fl_e;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          seed;
    int          i;
    int          k;

    dcc_cal_ctrl u_dut (
        .sys_clk(sys_clk), .srst(srst), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cal_done_in(cal_done_in), .cal_rset_code_in(cal_rset_code_in),
        .cal_comp_offset_in(cal_comp_offset_in), .cal_flags_in(cal_flags_in),
        .internal_resistor_enable(internal_resistor_enable),
        .resistor_setting(resistor_setting), .gain_cal_enable(gain_cal_enable),
        .comp_cal_range(comp_cal_range), .cal_busy(cal_busy), .cal_start(cal_start),
        .cal_clear(cal_clear), .cal_tick(cal_tick),
        .shadow_settings_transfer(shadow_settings_transfer)
    );

    // 40 mhz clock
    always #12.5 sys_clk = ~sys_clk;

    // hang guard: the longest part is the divider sweep, a few thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("ERROR %0t run timed out", $time);
            end_sim();
        end
    end

    // ************************************************************
    // tasks and expectation functions
    // ************************************************************
    task automatic end_sim;
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one-cycle write strobe, driven between falling edges
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    // registered read data is settled by the falling edge after the strobe
    task automatic rd(input logic [6:0] a);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        rd_val = reg_rdata;
    endtask

    // transfer strobe, then look for exactly one transfer pulse
    task automatic xfer;
        int n;
        wr(OFS_XFER, 16'h0001);
        n = 0;
        while (shadow_settings_transfer !== 1'b1 && n < 4)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk({15'h0, shadow_settings_transfer}, 16'h0001, "transfer pulse");
        @(negedge sys_clk);
        chk({15'h0, shadow_settings_transfer}, 16'h0000, "transfer width");
    endtask

    // cycles between two calibration ticks
    task automatic tick_gap(output int gap);
        int n;
        n = 0;
        while (cal_tick !== 1'b1 && n < 1100)
        begin
            @(negedge sys_clk);
            n++;
        end
        gap = 0;
        do
        begin
            @(negedge sys_clk);
            gap++;
        end
        while (cal_tick !== 1'b1 && gap < 1100);
    endtask

    function automatic logic [15:0] exp_rset(input logic [15:0] w, input logic busy,
                                             input logic [4:0] code);
        return {w[15] & busy, 2'b00, code, 3'b000, w[4:0]};
    endfunction

    function automatic logic [15:0] exp_cfg(input logic [15:0] w, input logic [5:0] fl,
                                            input logic busy);
        return {1'b0, fl, w[8], busy, w[6:0]};
    endfunction

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        seed = 97030;
        repeat (6) @(negedge sys_clk);
        srst = 1'b0;
        // reset values and an unmapped place
        rd(OFS_RSET1);
        chk(rd_val, 16'h000a, "rset reset");
        rd(OFS_CALCFG);
        chk(rd_val, 16'h0000, "cfg reset");
        rd(OFS_COMPOFF);
        chk(rd_val, 16'h0000, "offset reset");
        rd(7'h10);
        chk(rd_val, 16'h0000, "unmapped read");
        chk({11'h0, resistor_setting}, {11'h0, RSET_RST}, "active rset reset");
        // random settings with the range ends forced; active copy waits for transfer
        for (i = 0; i < 4; i++)
        begin
            rset_w = 16'($random(seed));
            rset_w[4:0] = RSET_MIN + 5'($unsigned($random(seed)) % 16);
            if (i == 0)
                rset_w[4:0] = RSET_MIN;
            if (i == 3)
                rset_w[4:0] = RSET_MAX;
            code_e = resistor_setting;
            wr(OFS_RSET1, rset_w);
            rd(OFS_RSET1);
            chk(rd_val, exp_rset(rset_w, 1'b0, 5'h00), "rset readback");
            chk({11'h0, resistor_setting}, {11'h0, code_e}, "active held");
            xfer();
            chk({11'h0, resistor_setting}, {11'h0, rset_w[4:0]}, "active rset");
            chk({15'h0, internal_resistor_enable}, {15'h0, rset_w[15]}, "enable");
        end
        // every divider code with the gate open, random gain and range
        for (i = 0; i < 8; i++)
        begin
            cfg_w = 16'h0008 | 16'(i) | (16'($random(seed)) & 16'h0070);
            wr(OFS_CALCFG, cfg_w);
            xfer();
            chk({15'h0, gain_cal_enable}, {15'h0, cfg_w[6]}, "gain enable");
            chk({14'h0, comp_cal_range}, {14'h0, cfg_w[5:4]}, "range");
            tick_gap(k);
            chk(16'(k), 16'h0001 << (i + 2), "tick period");
        end
        // gate closed: no ticks at all
        cfg_w = 16'h0047;
        wr(OFS_CALCFG, cfg_w);
        xfer();
        k = 0;
        repeat (600)
        begin
            @(negedge sys_clk);
            if (cal_tick === 1'b1)
                k++;
        end
        chk(16'(k), 16'h0000, "gated ticks");
        // slowest divider keeps the calibration clock under the limit
        cfg_w = 16'h004f;
        wr(OFS_CALCFG, cfg_w);
        rset_w = 16'h800a;
        wr(OFS_RSET1, rset_w);
        xfer();
        rd(OFS_RSET1);
        chk(rd_val, exp_rset(rset_w, 1'b0, 5'h00), "enable idle");
        // calibration runs, a second start while running, results latched
        for (i = 0; i < 3; i++)
        begin
            wr(OFS_COMPOFF, 16'h0001);
            chk({14'h0, cal_start, cal_busy}, 16'h0003, "start pulse");
            @(negedge sys_clk);
            chk({14'h0, cal_start, cal_busy}, 16'h0001, "start width");
            wr(OFS_COMPOFF, 16'h0001);
            chk({15'h0, cal_start}, 16'h0000, "restart ignored");
            rd(OFS_RSET1);
            chk(rd_val & 16'h8000, 16'h8000, "enable in run");
            rd(OFS_CALCFG);
            chk(rd_val & 16'h0080, 16'h0080, "in use flag");
            rd(OFS_COMPOFF);
            chk(rd_val & 16'h0002, 16'h0000, "done in run");
            code_e = 5'($random(seed));
            off_e = 7'($random(seed));
            fl_e = (i == 2) ? 6'h3f : 6'($random(seed));
            cal_rset_code_in = code_e;
            cal_comp_offset_in = off_e;
            cal_flags_in = fl_e;
            cal_done_in = 1'b1;
            @(negedge sys_clk);
            cal_done_in = 1'b0;
            cal_rset_code_in = ~code_e;
            cal_comp_offset_in = ~off_e;
            cal_flags_in = ~fl_e;
            chk({15'h0, cal_busy}, 16'h0000, "busy drops");
            rd(OFS_COMPOFF);
            chk(rd_val & 16'hfffe, {1'b0, off_e, 8'h02}, "offset result");
            rd(OFS_RSET1);
            chk(rd_val, exp_rset(rset_w, 1'b0, code_e), "cal code");
            rd(OFS_CALCFG);
            chk(rd_val, exp_cfg(cfg_w, fl_e, 1'b0), "flags");
        end
        // writes aimed at read-only results are dropped
        wr(OFS_COMPOFF, 16'h7ffc);
        wr(OFS_RSET1, rset_w | 16'h1f00);
        rd(OFS_COMPOFF);
        chk(rd_val & 16'hfffe, {1'b0, off_e, 8'h02}, "offset kept");
        rd(OFS_RSET1);
        chk(rd_val, exp_rset(rset_w, 1'b0, code_e), "code kept");
        // clear pulse: high then low wipes every result
        wr(OFS_CALCFG, cfg_w | 16'h0100);
        chk({15'h0, cal_clear}, 16'h0001, "clear pulse");
        @(negedge sys_clk);
        chk({15'h0, cal_clear}, 16'h0000, "clear width");
        wr(OFS_CALCFG, cfg_w);
        rd(OFS_COMPOFF);
        chk(rd_val & 16'hfffe, 16'h0000, "cleared offset");
        rd(OFS_CALCFG);
        chk(rd_val, exp_cfg(cfg_w, 6'h00, 1'b0), "cleared flags");
        rd(OFS_RSET1);
        chk(rd_val, exp_rset(rset_w, 1'b0, 5'h00), "cleared code");
        rd(OFS_XFER);
        chk(rd_val, 16'h0000, "update self clear");
        // ce low freezes state: a start written meanwhile is lost
        ce = 1'b0;
        wr(OFS_COMPOFF, 16'h0001);
        @(negedge sys_clk);
        chk({14'h0, cal_start, cal_busy}, 16'h0000, "frozen start");
        ce = 1'b1;
        // reset after a pending resistor write brings back the reset values
        wr(OFS_RSET1, 16'h8014);
        srst = 1'b1;
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        chk({11'h0, resistor_setting}, {11'h0, RSET_RST}, "active rset rerst");
        rd(OFS_RSET1);
        chk(rd_val, 16'h000a, "rset after rerst");
        end_sim();
    end

endmodule // tb_top
